// File: shared/aotr_map.vh
`ifndef AOTR_MAP_VH
`define AOTR_MAP_VH

// Printed register indexes; byte address on APB is four times the index
`define AOTR_IDX_C2A        12'h334
`define AOTR_IDX_C2B        12'h336
`define AOTR_IDX_C3C        12'h338
`define AOTR_IDX_C3D        12'h33A
`define AOTR_IDX_C4         12'h33C
`define AOTR_IDX_STATUS     12'h340

// Trim storage slots, also the fuse word addresses
`define AOTR_SLOT_C2A       3'h0
`define AOTR_SLOT_C2B       3'h1
`define AOTR_SLOT_C3C       3'h2
`define AOTR_SLOT_C3D       3'h3
`define AOTR_SLOT_C4        3'h4
`define AOTR_SLOT_LAST      3'h4
`define AOTR_SLOT_NONE      3'h7
`define AOTR_NUM_SLOTS      5

// Field layout
`define AOTR_TRIM_W         12
`define AOTR_TRIM_MSB       11
`define AOTR_RSVD_MSB       15
`define AOTR_RSVD_LSB       12
`define AOTR_TRIM_RESET     12'h000
`define AOTR_STAT_LOADED    0
`define AOTR_STAT_CALHIT    1

`endif

// File: verilog/aotr_fuse_loader.v
`include "aotr_map.vh"

module aotr_fuse_loader (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        fuse_valid,
  input  wire [11:0] fuse_rdata,
  output reg         fuse_rd,
  output reg  [2:0]  fuse_addr,
  output reg         load_we,
  output reg  [2:0]  load_slot,
  output reg  [11:0] load_data,
  output reg         load_done
);

  localparam [1:0] ST_REQ  = 2'b00;
  localparam [1:0] ST_WAIT = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  reg [1:0] state_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Walks the fuse words once after reset; fuse storage is on pclk
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_REQ;
      fuse_rd   <= 1'b0;
      fuse_addr <= 3'h0;
      load_we   <= 1'b0;
      load_slot <= 3'h0;
      load_data <= 12'h000;
      load_done <= 1'b0;
    end else begin
      load_we <= 1'b0;
      case (state_reg)
        ST_REQ: begin
          fuse_rd   <= 1'b1;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          fuse_rd <= 1'b0;
          if (fuse_valid) begin
            load_we   <= 1'b1;
            load_slot <= fuse_addr;
            load_data <= fuse_rdata;
            if (fuse_addr == `AOTR_SLOT_LAST) begin
              state_reg <= ST_DONE;
            end else begin
              fuse_addr <= fuse_addr + 3'h1;
              state_reg <= ST_REQ;
            end
          end
        end
        ST_DONE: begin
          load_done <= ~load_we ? 1'b1 : load_done;
        end
        default: begin
          state_reg <= ST_DONE;
        end
      endcase
    end
  end

endmodule // aotr_fuse_loader

// File: verilog/aotr_offset_select.v
`include "aotr_map.vh"

module aotr_offset_select (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [11:0] trim_c2a,
  input  wire [11:0] trim_c2b,
  input  wire [11:0] trim_c3c,
  input  wire [11:0] trim_c3d,
  input  wire [11:0] trim_c4,
  input  wire        core2_input_sel,
  input  wire        core3_input_sel,
  output reg  [11:0] core2_offset,
  output reg  [11:0] core3_offset,
  output reg  [11:0] core4_offset
);

  // Trims are passed as plain unsigned codes, never sign extended
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core2_offset <= `AOTR_TRIM_RESET;
      core3_offset <= `AOTR_TRIM_RESET;
      core4_offset <= `AOTR_TRIM_RESET;
    end else begin
      core2_offset <= core2_input_sel ? trim_c2b : trim_c2a;
      core3_offset <= core3_input_sel ? trim_c3d : trim_c3c;
      core4_offset <= trim_c4;
    end
  end

endmodule // aotr_offset_select

// File: verilog/aotr_regs.v
// Register access over APB is this design's own decision.
`include "aotr_map.vh"

module aotr_regs (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        fuse_valid,
  input  wire [11:0] fuse_rdata,
  output wire        fuse_rd,
  output wire [2:0]  fuse_addr,
  input  wire        offset_cal_busy,
  input  wire        core2_input_sel,
  input  wire        core3_input_sel,
  output wire [11:0] core2_offset,
  output wire [11:0] core3_offset,
  output wire [11:0] core4_offset
);

  reg  [11:0] trim_reg [0:`AOTR_NUM_SLOTS-1];
  reg         cal_hit_reg;
  wire        load_we;
  wire [2:0]  load_slot;
  wire [11:0] load_data;
  wire        load_done;
  wire [2:0]  slot;
  wire        is_status;
  wire        bad_addr;
  wire        access_ph;
  wire        answer;
  wire        commit;
  wire        wr_commit;
  wire [4:0]  load_hit;
  wire [4:0]  write_hit;
  wire        cal_set;
  wire        cal_clear;
  wire [15:0] core2_input_a_offset_trim;
  wire [15:0] core2_input_b_offset_trim;
  wire [15:0] core3_input_c_offset_trim;
  wire [15:0] core3_input_d_offset_trim;
  wire [15:0] core4_offset_trim;
  reg  [31:0] rdata_next;

  ////////////////////////////////////////////////////////////////////////////
  // Register index of a byte address; each register takes one aligned word
  function [11:0] word_index;
    input [11:0] addr;
    begin
      word_index = {2'h0, addr[11:2]};
    end
  endfunction

  // Trim slot of an address, or none for status, unmapped and unaligned ones
  function [2:0] slot_of;
    input [11:0] addr;
    begin
      if (addr[1:0] != 2'h0) begin
        slot_of = `AOTR_SLOT_NONE;
      end else begin
        case (word_index(addr))
          `AOTR_IDX_C2A: slot_of = `AOTR_SLOT_C2A;
          `AOTR_IDX_C2B: slot_of = `AOTR_SLOT_C2B;
          `AOTR_IDX_C3C: slot_of = `AOTR_SLOT_C3C;
          `AOTR_IDX_C3D: slot_of = `AOTR_SLOT_C3D;
          `AOTR_IDX_C4:  slot_of = `AOTR_SLOT_C4;
          default:       slot_of = `AOTR_SLOT_NONE;
        endcase
      end
    end
  endfunction

  assign slot      = slot_of(paddr);
  assign is_status = (paddr[1:0] == 2'h0) && (word_index(paddr) == `AOTR_IDX_STATUS);
  assign bad_addr  = (slot == `AOTR_SLOT_NONE) && !is_status;
  assign access_ph = psel & penable;
  assign answer    = access_ph & load_done & ~pready;
  assign commit    = access_ph & pready;
  assign wr_commit = commit & pwrite;

  // One-hot slot strobes; the none code shifts out of the five bits
  assign load_hit  = load_we ? (5'h01 << load_slot) : 5'h00;
  assign write_hit = wr_commit ? (5'h01 << slot) : 5'h00;

  // A trim access and a status write never fall in one transfer
  assign cal_set   = commit & offset_cal_busy & (slot != `AOTR_SLOT_NONE);
  assign cal_clear = wr_commit & is_status & pwdata[`AOTR_STAT_CALHIT];

  // Sixteen-bit software views; bits 15:12 are not stored, so they read zero
  assign core2_input_a_offset_trim = {4'h0, trim_reg[`AOTR_SLOT_C2A]};
  assign core2_input_b_offset_trim = {4'h0, trim_reg[`AOTR_SLOT_C2B]};
  assign core3_input_c_offset_trim = {4'h0, trim_reg[`AOTR_SLOT_C3C]};
  assign core3_input_d_offset_trim = {4'h0, trim_reg[`AOTR_SLOT_C3D]};
  assign core4_offset_trim         = {4'h0, trim_reg[`AOTR_SLOT_C4]};

  ////////////////////////////////////////////////////////////////////////////
  // Fuse load runs first; the bus is stalled until it has finished
  aotr_fuse_loader u_loader (
    .pclk       (pclk),
    .presetn    (presetn),
    .fuse_valid (fuse_valid),
    .fuse_rdata (fuse_rdata),
    .fuse_rd    (fuse_rd),
    .fuse_addr  (fuse_addr),
    .load_we    (load_we),
    .load_slot  (load_slot),
    .load_data  (load_data),
    .load_done  (load_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Trim storage; only the 12-bit field is kept, reserved bits read zero
  genvar gi;
  generate
    for (gi = 0; gi < `AOTR_NUM_SLOTS; gi = gi + 1) begin : g_trim
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          trim_reg[gi] <= `AOTR_TRIM_RESET;
        end else if (load_hit[gi]) begin
          trim_reg[gi] <= load_data;
        end else if (write_hit[gi]) begin
          trim_reg[gi] <= pwdata[`AOTR_TRIM_MSB:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read mux over the named views; the status word holds only two flags
  always @* begin
    rdata_next = 32'h0000_0000;
    case (slot)
      `AOTR_SLOT_C2A: rdata_next[`AOTR_RSVD_MSB:0] = core2_input_a_offset_trim;
      `AOTR_SLOT_C2B: rdata_next[`AOTR_RSVD_MSB:0] = core2_input_b_offset_trim;
      `AOTR_SLOT_C3C: rdata_next[`AOTR_RSVD_MSB:0] = core3_input_c_offset_trim;
      `AOTR_SLOT_C3D: rdata_next[`AOTR_RSVD_MSB:0] = core3_input_d_offset_trim;
      `AOTR_SLOT_C4:  rdata_next[`AOTR_RSVD_MSB:0] = core4_offset_trim;
      default: begin
        if (is_status) begin
          rdata_next[`AOTR_STAT_LOADED] = load_done;
          rdata_next[`AOTR_STAT_CALHIT] = cal_hit_reg;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, and nothing is answered before the fuse load ends
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'h0;
    end else begin
      pready <= answer;
    end
  end

  // An error answer carries no data, and its write has already been dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'h0;
    end else begin
      pslverr <= answer & bad_addr;
    end
  end

  // Read data stands from one answer until the next
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (answer) begin
      prdata <= pwrite ? 32'h0000_0000 : rdata_next;
    end
  end

  // Sticky flag for a trim access during offset calibration; set wins over clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_hit_reg <= 1'h0;
    end else if (cal_set) begin
      cal_hit_reg <= 1'h1;
    end else if (cal_clear) begin
      cal_hit_reg <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  aotr_offset_select u_select (
    .pclk            (pclk),
    .presetn         (presetn),
    .trim_c2a        (trim_reg[`AOTR_SLOT_C2A]),
    .trim_c2b        (trim_reg[`AOTR_SLOT_C2B]),
    .trim_c3c        (trim_reg[`AOTR_SLOT_C3C]),
    .trim_c3d        (trim_reg[`AOTR_SLOT_C3D]),
    .trim_c4         (trim_reg[`AOTR_SLOT_C4]),
    .core2_input_sel (core2_input_sel),
    .core3_input_sel (core3_input_sel),
    .core2_offset    (core2_offset),
    .core3_offset    (core3_offset),
    .core4_offset    (core4_offset)
  );

endmodule // aotr_regs

// File: sim/aotr_regs_monitor.sv
module aotr_regs_chk (
  input logic        pclk,
  input logic        presetn,
  input logic [11:0] paddr,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  input logic        fuse_valid,
  input logic [11:0] fuse_rdata,
  input logic        fuse_rd,
  input logic [2:0]  fuse_addr,
  input logic        core2_input_sel,
  input logic        core3_input_sel,
  input logic [11:0] core2_offset,
  input logic [11:0] core3_offset,
  input logic [11:0] core4_offset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Committed register write at this edge
  wire wr = psel && penable && pready && pwrite && !pslverr;
  a_core2_first: assert property ((wr && paddr == 12'hCD0) ##1 !core2_input_sel |-> ##1 core2_offset == $past(pwdata[11:0], 2))
    else $error("core2 first trim not applied");
  a_core2_second: assert property ((wr && paddr == 12'hCD8) ##1 core2_input_sel |-> ##1 core2_offset == $past(pwdata[11:0], 2))
    else $error("core2 second trim not applied");
  a_core3_third: assert property ((wr && paddr == 12'hCE0) ##1 !core3_input_sel |-> ##1 core3_offset == $past(pwdata[11:0], 2))
    else $error("core3 third trim not applied");
  a_core3_fourth: assert property ((wr && paddr == 12'hCE8) ##1 core3_input_sel |-> ##1 core3_offset == $past(pwdata[11:0], 2))
    else $error("core3 fourth trim not applied");
  a_core4_trim: assert property (wr && paddr == 12'hCF0 |-> ##2 core4_offset == $past(pwdata[11:0], 2))
    else $error("core4 trim not applied");
  a_fuse_last: assert property (fuse_valid && fuse_addr == 3'h4 |-> ##3 core4_offset == $past(fuse_rdata, 3))
    else $error("fuse word not loaded");
  a_fuse_pulse: assert property (fuse_rd |=> !fuse_rd)
    else $error("fuse read not a pulse");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
endmodule // aotr_regs_chk

bind aotr_regs aotr_regs_chk i_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .fuse_valid(fuse_valid), .fuse_rdata(fuse_rdata), .fuse_rd(fuse_rd), .fuse_addr(fuse_addr),
  .core2_input_sel(core2_input_sel), .core3_input_sel(core3_input_sel), .core2_offset(core2_offset),
  .core3_offset(core3_offset), .core4_offset(core4_offset));

// File: sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        fuse_valid, fuse_rd, offset_cal_busy, core2_input_sel, core3_input_sel;
  logic [11:0] paddr, fuse_rdata, core2_offset, core3_offset, core4_offset;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  fuse_addr;
  int          fails, samples_checked;
  localparam logic [11:0] WV [5] = '{12'hFFF, 12'h800, 12'h001, 12'h7FF, 12'hC35};
  aotr_regs i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fuse_valid(fuse_valid), .fuse_rdata(fuse_rdata), .fuse_rd(fuse_rd), .fuse_addr(fuse_addr),
    .offset_cal_busy(offset_cal_busy), .core2_input_sel(core2_input_sel), .core3_input_sel(core3_input_sel),
    .core2_offset(core2_offset), .core3_offset(core3_offset), .core4_offset(core4_offset));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Fuse storage answers one cycle after each read pulse
  always @(posedge pclk) begin
    fuse_valid <= fuse_rd;
    fuse_rdata <= 12'hA50 + {9'h000, fuse_addr};
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Idle edge at the end keeps psel from being assigned twice in one step
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_load;
    apb(12'hD00, 1'b0, 32'h0);
    chk("loaded", 32'h1, {31'h0, rd[0]});
    for (int i = 0; i < 5; i++) begin
      apb(12'(12'hCD0 + 8 * i), 1'b0, 32'h0);
      chk("fuse trim", 32'hA50 + i, rd);
    end
    chk("core2 a", 32'hA50, {20'h0, core2_offset});
    chk("core3 c", 32'hA52, {20'h0, core3_offset});
    chk("core4", 32'hA54, {20'h0, core4_offset});
    core2_input_sel <= 1'b1;
    core3_input_sel <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("core2 b", 32'hA51, {20'h0, core2_offset});
    chk("core3 d", 32'hA53, {20'h0, core3_offset});
  endtask
  task automatic t_write;
    for (int i = 0; i < 5; i++) begin
      core2_input_sel <= i[0];
      core3_input_sel <= i[0];
      apb(12'(12'hCD0 + 8 * i), 1'b1, {20'h0, WV[i]});
    end
    for (int i = 0; i < 5; i++) begin
      apb(12'(12'hCD0 + 8 * i), 1'b0, 32'h0);
      chk("trim readback", {20'h0, WV[i]}, rd);
    end
    chk("core2 a new", {20'h0, WV[0]}, {20'h0, core2_offset});
    chk("core3 c new", {20'h0, WV[2]}, {20'h0, core3_offset});
  endtask
  task automatic t_err;
    apb(12'hCD2, 1'b1, 32'h123);
    chk("unaligned err", 32'h1, {31'h0, er});
    apb(12'hD04, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(12'hCD0, 1'b0, 32'h0);
    chk("trim kept", {20'h0, WV[0]}, rd);
  endtask
  task automatic t_cal;
    offset_cal_busy <= 1'b1;
    apb(12'hCD8, 1'b0, 32'h0);
    offset_cal_busy <= 1'b0;
    apb(12'hD00, 1'b0, 32'h0);
    chk("cal flag", 32'h3, {30'h0, rd[1:0]});
    apb(12'hD00, 1'b1, 32'h2);
    apb(12'hD00, 1'b0, 32'h0);
    chk("cal flag clear", 32'h1, {30'h0, rd[1:0]});
  endtask
  task automatic t_reset;
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    chk("reset c2 offset", 32'h0, {20'h0, core2_offset});
    chk("reset pready", 32'h0, {31'h0, pready});
    presetn <= 1'h1;
    apb(12'hD00, 1'h0, 32'h0);
    chk("reload status", 32'h1, {30'h0, rd[1:0]});
    apb(12'hCD0, 1'h0, 32'h0);
    chk("reload c2a", 32'hA50, rd);
  endtask
  task automatic report_and_stop;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge pclk);
    fails++;
    report_and_stop;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {offset_cal_busy, core2_input_sel, core3_input_sel} = '0;
    repeat (16) @(posedge pclk);
    chk("reset offsets", 32'h0, {20'h0, core2_offset | core3_offset | core4_offset});
    presetn <= 1'b1;
    t_load;
    t_write;
    t_err;
    t_cal;
    t_reset;
    report_and_stop;
  end
endmodule // tb
